// ---- analog_output_module_register_map_tb.sv ----
// self-checking bench for the analog output register bank
`timescale 1ns/100ps
module analog_output_module_register_map_tb;
	import aomrm_pkg::*;
	localparam int MSC = 3;
	localparam int TC  = 4;
	logic             mclk, rst_n, node_match, host_frame, dout_cmd, resp_req, resp_go;
	logic             proto_modbus, fmt_eng, wd_timeout, e, k;
	aomrm_req_t       req;
	aomrm_rsp_t       rsp;
	aomrm_ser_t       ser_cfg;
	logic [7:0]       frame_node;
	logic [3:0][15:0] di_count, out_code;
	logic [15:0]      slew_rate, q, v;
	logic [31:0]      seed = 32'ha07b29b1;
	int               errors, cmp_count, n;
	logic [31:0]      rtab[6] = '{{A_NODE, RST_NODE}, {A_SERIAL, RST_SERIAL},
		{A_TYPE, RST_TYPE}, {A_DELAY, 16'h0000}, {A_WDTO, 16'h0000}, {A_TALLY, 16'h0000}};
	logic [32:0]      lim[16] = '{{1'b1, A_NODE, 16'h0000}, {1'b1, A_NODE, 16'h00f8},
		{1'b0, A_NODE, 16'h00f7}, {1'b1, A_DELAY, 16'h001f}, {1'b0, A_DELAY, 16'h001e},
		{1'b1, A_WDTO, 16'h0100}, {1'b0, A_WDTO, 16'h00ff}, {1'b1, A_SERIAL, 16'h0002},
		{1'b1, A_SERIAL, 16'h000b}, {1'b1, A_TYPE, 16'h002f}, {1'b1, A_TYPE, 16'h0036},
		{1'b1, A_RDBK, 16'h0000}, {1'b1, A_DICNT, 16'h0000}, {1'b1, A_FWLO, 16'h0000},
		{1'b1, 16'h9e2a, 16'h0000}, {1'b1, 16'h0102, 16'h0000}};
	logic [15:0]      emax[6] = '{16'h4e20, 16'h4e20, 16'h2710, 16'h2710, 16'h1388, 16'h1388};
	logic [15:0]      emin[6] = '{16'h0000, 16'h0fa0, 16'h0000, 16'hd8f0, 16'h0000, 16'hec78};

	aomrm_regbank #(.MS_CYCLES(MSC), .TENTH_CYC(TC)) uut (
		.mclk(mclk), .rst_n(rst_n), .req(req), .rsp(rsp), .frame_node(frame_node),
		.node_match(node_match), .host_frame(host_frame), .dout_cmd(dout_cmd),
		.resp_req(resp_req), .resp_go(resp_go), .di_count(di_count), .out_code(out_code),
		.slew_rate(slew_rate), .ser_cfg(ser_cfg), .proto_modbus(proto_modbus),
		.fmt_eng(fmt_eng), .wd_timeout(wd_timeout));
	aomrm_host host (.mclk(mclk), .req(req), .rsp(rsp));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [15:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[15:0];
	endfunction
	function automatic aomrm_ser_t ser_exp(input logic [7:0] s);
		int b[8] = '{1200, 2400, 4800, 9600, 19200, 38400, 57600, 115200};
		return '{1'b1, 17'(b[s[5:0] - 3]), s[7] ? (s[6] ? PAR_ODD : PAR_EVEN) : PAR_NONE,
			s[7:6] == 2'b01};
	endfunction
	task automatic check(input logic [31:0] g, input logic [31:0] x);
		cmp_count++;
		if (g !== x) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, g, x);
		end
	endtask
	task automatic cyc(input int c);
		repeat (c) @(posedge mclk);
		#10;
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic x);
		host.access(1'b1, a, d, q, e, k);
		check({k, e}, {1'b1, x});
	endtask
	task automatic rdc(input logic [15:0] a, input logic [15:0] d);
		host.access(1'b0, a, 16'h0000, q, e, k);
		check({k, e, q}, {2'b10, d});
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic bound_hit();
		check(1'b0, 1'b1);
		report_and_stop();
	endtask
	task automatic wait_to();
		n = 0;
		while (wd_timeout !== 1'b1 && n < 40) begin
			cyc(1);
			n++;
		end
		if (n >= 40) bound_hit();
	endtask
	task automatic resp_test(input logic [15:0] d);
		wr(A_DELAY, d, 1'b0);
		resp_req = 1'b1;
		cyc(1);
		resp_req = 1'b0;
		n = 1;
		while (resp_go !== 1'b1 && n < 120) begin
			cyc(1);
			n++;
		end
		if (n >= 120) bound_hit();
		check(n, (d == 0) ? 1 : d * MSC + 1);
	endtask

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		host_frame = 1'b0;
		dout_cmd = 1'b0;
		resp_req = 1'b0;
		frame_node = 8'h00;
		di_count = '0;
		errors = 0;
		cmp_count = 0;
		repeat (20) @(posedge mclk);
		#10;
		rst_n = 1'b1;
		check({proto_modbus, fmt_eng, wd_timeout}, 3'b100);
		for (int i = 0; i < 6; i++) rdc(rtab[i][31:16], rtab[i][15:0]);
		rdc(A_FIRST, 16'h0001);
		rdc(A_FIRST, 16'h0000);
		wr(A_FIRST, 16'h0001, 1'b1);
		$display("reset values done");
		for (int i = 0; i < 16; i++) begin
			wr(lim[i][31:16], lim[i][15:0], lim[i][32]);
			if (!lim[i][32]) rdc(lim[i][31:16], lim[i][15:0]);
		end
		for (int i = 0; i < 32; i++) begin
			v = {8'h00, i[4:3], 6'(i[2:0] + 3)};
			wr(A_SERIAL, v, 1'b0);
			check(32'(ser_cfg), 32'(ser_exp(v[7:0])));
		end
		wr(A_PROTO, 16'h0000, 1'b0);
		check(proto_modbus, 1'b0);
		v = xs();
		wr(A_SLEW, v, 1'b0);
		check(slew_rate, v);
		wr(A_PWRON + 16'h0003, v, 1'b0);
		rdc(A_PWRON + 16'h0003, v);
		rdc(A_SAFE, 16'h0000);
		$display("limits and serial done");
		for (int i = 0; i < 16; i++) begin
			v = xs();
			frame_node = (i == 0) ? 8'hf7 : v[7:0];
			di_count[i % 4] = xs();
			cyc(1);
			check(node_match, frame_node == 8'hf7);
		end
		cyc(1);
		for (int i = 0; i < 4; i++) rdc(A_DICNT + 16'(i), di_count[i]);
		resp_test(16'h0000);
		resp_test(16'h001e);
		for (int i = 0; i < 3; i++) resp_test(16'h0001 + (xs() % 16'h001d));
		$display("node and delay done");
		wr(A_FMT, 16'h0001, 1'b0);
		check(fmt_eng, 1'b1);
		for (int i = 0; i < 6; i++) begin
			wr(A_TYPE, 16'h0030 + 16'(i), 1'b0);
			wr(A_AOVAL, emax[i], 1'b0);
			check(out_code[0], 16'h3fff);
			rdc(A_RDBK, emax[i]);
			wr(A_AOVAL, emin[i], 1'b0);
			check(out_code[0], (i == 3 || i == 5) ? 16'hc000 : 16'h0000);
			rdc(A_RDBK, emin[i]);
		end
		wr(A_FMT, 16'h0000, 1'b0);
		wr(A_TYPE, 16'h0030, 1'b0);
		for (int i = 0; i < 4; i++) begin
			v = xs() & 16'h3fff;
			wr(A_AOVAL + 16'(i), v, 1'b0);
			check(out_code[i], v);
			rdc(A_RDBK + 16'(i), v);
		end
		$display("output codes done");
		wr(A_SAFE, 16'h1234, 1'b0);
		rdc(A_SAFE, 16'h1234);
		wr(A_WDTO, 16'h0002, 1'b0);
		cyc(40);
		check(wd_timeout, 1'b0);
		wr(A_WDEN, 16'h0001, 1'b0);
		host_frame = 1'b1;
		cyc(1);
		host_frame = 1'b0;
		wait_to();
		check(n >= 2 * TC - 1 && n <= 2 * TC + 1, 1'b1);
		rdc(A_TALLY, 16'h0001);
		check(out_code[0], 16'h1234);
		dout_cmd = 1'b1;
		cyc(1);
		dout_cmd = 1'b0;
		check(wd_timeout, 1'b1);
		wr(A_WDFLAG, 16'h0001, 1'b0);
		check(wd_timeout, 1'b0);
		wr(A_WDMODE, 16'h0001, 1'b0);
		wait_to();
		dout_cmd = 1'b1;
		cyc(1);
		dout_cmd = 1'b0;
		check(wd_timeout, 1'b0);
		wait_to();
		wr(A_AOVAL, 16'h0100, 1'b0);
		check(wd_timeout, 1'b0);
		wr(A_WDEN, 16'h0000, 1'b0);
		rdc(A_TALLY, 16'h0003);
		wr(A_TALLY, 16'h0000, 1'b0);
		rdc(A_TALLY, 16'h0000);
		$display("watchdog done");
		report_and_stop();
	end
endmodule

// ---- aomrm_host.sv ----
// host model issuing register accesses one at a time
`timescale 1ns/100ps
module aomrm_host (
	input  wire logic             mclk,
	output aomrm_pkg::aomrm_req_t req,
	input  aomrm_pkg::aomrm_rsp_t rsp
);
	import aomrm_pkg::*;
	initial req = '0;
	// one request cycle, answer taken a cycle later; released address and data
	// lines show the inverse so a stale value cannot pass for a live one
	task automatic access(input logic w, input logic [15:0] a, input logic [15:0] d,
		output logic [15:0] q, output logic e, output logic k);
		req = '{~w, w, a, d};
		@(posedge mclk);
		#10;
		req = '{1'b0, 1'b0, ~a, ~d};
		k = rsp.ack;
		e = rsp.err;
		q = rsp.rdata;
		@(posedge mclk);
		#10;
	endtask
endmodule

// ---- aomrm_pkg.sv ----
// shared constants and types for the analog output register bank
package aomrm_pkg;
	// --------------------------------------------------------------
	// register addresses, coils and holding registers in one space
	// --------------------------------------------------------------
	localparam logic [15:0] A_PROTO  = 16'h0101;
	localparam logic [15:0] A_WDMODE = 16'h0104;
	localparam logic [15:0] A_WDEN   = 16'h0105;
	localparam logic [15:0] A_FMT    = 16'h010d;
	localparam logic [15:0] A_WDFLAG = 16'h010e;
	localparam logic [15:0] A_FIRST  = 16'h0111;
	localparam logic [15:0] A_AOVAL  = 16'h9c41;
	localparam logic [15:0] A_RDBK   = 16'h9c81;
	localparam logic [15:0] A_SAFE   = 16'h9ca1;
	localparam logic [15:0] A_DICNT  = 16'h9cc1;
	localparam logic [15:0] A_PWRON  = 16'h9d01;
	localparam logic [15:0] A_FWLO   = 16'h9e21;
	localparam logic [15:0] A_FWHI   = 16'h9e22;
	localparam logic [15:0] A_NAMELO = 16'h9e23;
	localparam logic [15:0] A_NAMEHI = 16'h9e24;
	localparam logic [15:0] A_NODE   = 16'h9e25;
	localparam logic [15:0] A_SERIAL = 16'h9e26;
	localparam logic [15:0] A_TYPE   = 16'h9e27;
	localparam logic [15:0] A_DELAY  = 16'h9e28;
	localparam logic [15:0] A_WDTO   = 16'h9e29;
	localparam logic [15:0] A_TALLY  = 16'h9e2c;
	localparam logic [15:0] A_SLEW   = 16'h9e2e;
	// --------------------------------------------------------------
	// reset values, limits, field positions
	// --------------------------------------------------------------
	localparam logic [15:0] RST_NODE   = 16'h0001;
	localparam logic [15:0] RST_SERIAL = 16'h0006;
	localparam logic [15:0] RST_TYPE   = 16'h0030;
	localparam logic [15:0] RST_ZERO   = 16'h0000;
	localparam logic [15:0] NODE_MAX   = 16'h00f7;
	localparam logic [15:0] DELAY_MAX  = 16'h001e;
	localparam logic [15:0] WDTO_MAX   = 16'h00ff;
	localparam logic [5:0]  BAUD_MIN   = 6'h03;
	localparam logic [5:0]  BAUD_MAX   = 6'h0a;
	localparam int          BAUD_LSB   = 0;
	localparam int          FRAME_LSB  = 6;
	localparam int          HEX_FULL   = 16383;
	// --------------------------------------------------------------
	// timing
	// --------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int MS_NS         = 1000000;
	localparam int TENTH_NS      = 100000000;
	localparam int MS_CYC        = MS_NS / CLK_PERIOD_NS;
	localparam int TENTH_CYC     = TENTH_NS / CLK_PERIOD_NS;
	// --------------------------------------------------------------
	// types
	// --------------------------------------------------------------
	typedef enum logic [1:0] {PAR_NONE, PAR_EVEN, PAR_ODD} aomrm_par_t;
	typedef enum logic [2:0] {
		DLY_IDLE = 3'b001,
		DLY_WAIT = 3'b010,
		DLY_GO   = 3'b100
	} aomrm_dly_t;
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [15:0] addr;
		logic [15:0] wdata;
	} aomrm_req_t;
	typedef struct packed {
		logic        ack;
		logic        err;
		logic [15:0] rdata;
	} aomrm_rsp_t;
	typedef struct packed {
		logic        baud_ok;
		logic [16:0] baud_rate;
		aomrm_par_t  parity;
		logic        two_stop;
	} aomrm_ser_t;
endpackage

// ---- aomrm_regbank.sv ----
// register bank of the four-channel analog output module
// How it works
// [RQ1] protocol coil: 0 legacy ascii protocol, 1 modbus rtu
// [RQ2] watchdog mode 1 lets a valid output write clear the timeout flag
// [RQ3] watchdog supervises only while its enable coil is 1
// [RQ4] data format coil: 0 raw hex codes, 1 engineering units
// [RQ5] expiry sets the timeout flag; host writes 1 to clear it
// [RQ6] power-up flag reads 1 once, then 0 until next power-up
// [RQ7] timeout tally counts expiries; writing 0 clears it
// [RQ8] responses delayed by programmed milliseconds, 0 to 30 accepted
// [RQ9] node address 1 to 247; only matching frames answered
// [RQ10] serial bits 7:6 pick parity and stop bits
// [RQ11] watchdog timeout 0 to 255 in tenths of a second
// [RQ12] serial bits 5:0 codes 03h to 0ah select 1200 to 115200 baud
// [RQ13] per type code, hex 0000h/c000h..3fffh maps to engineering range
`timescale 1ns/100ps
module aomrm_regbank #(
	parameter int          N_CH      = 4,
	parameter int          MS_CYCLES = aomrm_pkg::MS_CYC,
	parameter int          TENTH_CYC = aomrm_pkg::TENTH_CYC,
	parameter logic [15:0] FW_LO     = 16'h0001,
	parameter logic [15:0] FW_HI     = 16'h0000,
	parameter logic [15:0] NAME_LO   = 16'h0000,
	parameter logic [15:0] NAME_HI   = 16'h0000
) (
	input  wire logic                   mclk,
	input  wire logic                   rst_n,
	input  aomrm_pkg::aomrm_req_t       req,
	output aomrm_pkg::aomrm_rsp_t       rsp,
	input  wire logic [7:0]             frame_node,
	output logic                        node_match,
	input  wire logic                   host_frame,
	input  wire logic                   dout_cmd,
	input  wire logic                   resp_req,
	output logic                        resp_go,
	input  wire logic [N_CH-1:0][15:0]  di_count,
	output logic [N_CH-1:0][15:0]       out_code,
	output logic [15:0]                 slew_rate,
	output aomrm_pkg::aomrm_ser_t       ser_cfg,
	output logic                        proto_modbus,
	output logic                        fmt_eng,
	output logic                        wd_timeout
);
	import aomrm_pkg::*;

	// tick and millisecond counters are 20 bits wide
	if (N_CH < 1 || N_CH > 32 || MS_CYCLES < 1 || MS_CYCLES > 1048576
		|| TENTH_CYC < 1 || TENTH_CYC > 1048576) begin : g_param_check
		$error("aomrm_regbank: unsupported parameter value");
	end

	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------
	function automatic int eng_lo(input logic [15:0] t);
		case (t[7:0])
			8'h31:   return 4000;
			8'h33:   return -10000;
			8'h35:   return -5000;
			default: return 0;
		endcase
	endfunction

	function automatic int eng_hi(input logic [15:0] t);
		case (t[7:0])
			8'h32, 8'h33: return 10000;
			8'h34, 8'h35: return 5000;
			default:      return 20000;
		endcase
	endfunction

	// engineering value to output code, clamped to the type's engineering range
	function automatic logic [15:0] to_code(input logic [15:0] t, input logic [15:0] v);
		int lo;
		int hi;
		int x;
		lo = eng_lo(t);
		hi = eng_hi(t);
		x  = int'($signed(v));
		if (x > hi)
			x = hi;
		if (x < lo)
			x = lo;
		// bipolar: the negative side spans one code more than the positive side
		if (lo < 0 && x < 0)
			x = x * (HEX_FULL + 1) / (-lo);
		else if (lo < 0)
			x = x * HEX_FULL / hi;
		else
			x = (x - lo) * HEX_FULL / (hi - lo);
		return x[15:0];
	endfunction

	function automatic logic [15:0] to_eng(input logic [15:0] t, input logic [15:0] c);
		int lo;
		int hi;
		int x;
		lo = eng_lo(t);
		hi = eng_hi(t);
		if (lo < 0 && c[15])
			x = int'($signed(c)) * (-lo) / (HEX_FULL + 1);
		else if (lo < 0)
			x = int'($signed(c)) * hi / HEX_FULL;
		else
			x = int'(c) * (hi - lo) / HEX_FULL + lo;
		return x[15:0];
	endfunction

	// channel index into a window, or -1 when outside it
	function automatic int ch_of(input logic [15:0] a, input logic [15:0] base);
		logic [15:0] d;
		d = a - base;
		return (d < 16'(N_CH)) ? int'(d) : -1;
	endfunction

	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	logic [N_CH-1:0][15:0] ao_val;
	logic [N_CH-1:0][15:0] safe_val;
	logic [N_CH-1:0][15:0] pwron_val;
	logic        wd_mode;
	logic        wd_en;
	logic        first_rd;
	logic [15:0] node_addr;
	logic [15:0] serial;
	logic [15:0] type_code;
	logic [15:0] delay_ms;
	logic [15:0] wdto;
	logic [15:0] tally;
	logic [19:0] tick_cnt;
	logic [7:0]  tenths;
	logic        expire;
	logic [4:0]  ms_left;
	logic [19:0] ms_cnt;
	aomrm_dly_t  dly_st;

	// ------------------------------------------------------------
	// decode and write qualification
	// ------------------------------------------------------------
	int   ao_ch;
	int   safe_ch;
	int   pwr_ch;
	logic wr_ok;
	logic wr_bad;
	logic ao_wr;

	always_comb begin
		ao_ch   = ch_of(req.addr, A_AOVAL);
		safe_ch = ch_of(req.addr, A_SAFE);
		pwr_ch  = ch_of(req.addr, A_PWRON);
		wr_bad  = 1'b0;
		case (req.addr)
			A_NODE:   wr_bad = req.wdata == 16'h0000 || req.wdata > NODE_MAX; // RQ9
			A_SERIAL: wr_bad = req.wdata[BAUD_LSB +: 6] < BAUD_MIN
				|| req.wdata[BAUD_LSB +: 6] > BAUD_MAX; // RQ12
			A_DELAY:  wr_bad = req.wdata > DELAY_MAX; // RQ8
			A_WDTO:   wr_bad = req.wdata > WDTO_MAX; // RQ11
			A_TYPE:   wr_bad = req.wdata < 16'h0030 || req.wdata > 16'h0035;
			default:  wr_bad = 1'b0;
		endcase
		wr_ok = req.wr && !wr_bad;
		ao_wr = wr_ok && ao_ch >= 0;
	end

	// ------------------------------------------------------------
	// control coils
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			proto_modbus <= 1'b1;
			wd_mode      <= 1'b0;
			wd_en        <= 1'b0;
			fmt_eng      <= 1'b0;
		end else if (wr_ok) begin
			case (req.addr)
				A_PROTO:  proto_modbus <= req.wdata[0]; // RQ1
				A_WDMODE: wd_mode      <= req.wdata[0]; // RQ2
				A_WDEN:   wd_en        <= req.wdata[0]; // RQ3
				A_FMT:    fmt_eng      <= req.wdata[0]; // RQ4
				default:  ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// holding registers
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			node_addr <= RST_NODE;
			serial    <= RST_SERIAL;
			type_code <= RST_TYPE;
			delay_ms  <= RST_ZERO;
			wdto      <= RST_ZERO;
			slew_rate <= RST_ZERO;
		end else if (wr_ok) begin
			case (req.addr)
				A_NODE:   node_addr <= req.wdata; // RQ9
				A_SERIAL: serial    <= req.wdata; // RQ10
				A_TYPE:   type_code <= req.wdata;
				A_DELAY:  delay_ms  <= req.wdata; // RQ8
				A_WDTO:   wdto      <= req.wdata; // RQ11
				A_SLEW:   slew_rate <= req.wdata;
				default:  ;
			endcase
		end
	end

	// values are stored in the format selected at write time
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ao_val    <= '0;
			safe_val  <= '0;
			pwron_val <= '0;
		end else begin
			if (ao_wr)
				ao_val[ao_ch] <= req.wdata;
			if (wr_ok && safe_ch >= 0)
				safe_val[safe_ch] <= req.wdata;
			if (wr_ok && pwr_ch >= 0)
				pwron_val[pwr_ch] <= req.wdata;
		end
	end

	// ------------------------------------------------------------
	// host watchdog
	// ------------------------------------------------------------
	// zero timeout is treated as off, else it would wrap and expire after 256 tenths
	always_comb begin
		expire = wd_en && !wd_timeout && wdto != RST_ZERO && !host_frame // RQ3
			&& tenths == wdto[7:0] - 8'h01 && tick_cnt == 20'(TENTH_CYC - 1); // RQ11
	end

	always_ff @(posedge mclk) begin
		if (!rst_n || !wd_en || host_frame || wd_timeout) begin
			tick_cnt <= '0;
			tenths   <= '0;
		end else if (tick_cnt == 20'(TENTH_CYC - 1)) begin
			tick_cnt <= '0;
			tenths   <= tenths + 8'h01;
		end else begin
			tick_cnt <= tick_cnt + 20'h00001;
		end
	end

	// set wins over the write-one clear and the mode 1 clear
	always_ff @(posedge mclk) begin
		if (!rst_n)
			wd_timeout <= 1'b0;
		else if (expire)
			wd_timeout <= 1'b1; // RQ5
		else if (wr_ok && req.addr == A_WDFLAG && req.wdata[0])
			wd_timeout <= 1'b0; // RQ5
		else if (wd_mode && (ao_wr || dout_cmd))
			wd_timeout <= 1'b0; // RQ2
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			tally <= RST_ZERO;
		else if (expire)
			tally <= (wr_ok && req.addr == A_TALLY && req.wdata == RST_ZERO) ? 16'h0001
				: (tally == 16'hffff ? tally : tally + 16'h0001); // RQ7
		else if (wr_ok && req.addr == A_TALLY && req.wdata == RST_ZERO)
			tally <= RST_ZERO; // RQ7
	end

	// ------------------------------------------------------------
	// output drive
	// ------------------------------------------------------------
	// the timed-out module falls back to safe values until cleared
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			out_code <= '0;
		end else begin
			for (int i = 0; i < N_CH; i++) begin
				if (fmt_eng)
					out_code[i] <= to_code(type_code, wd_timeout ? safe_val[i] : ao_val[i]); // RQ13
				else
					out_code[i] <= wd_timeout ? safe_val[i] : ao_val[i]; // RQ4
			end
		end
	end

	// ------------------------------------------------------------
	// serial settings and addressing
	// ------------------------------------------------------------
	always_comb begin
		node_match        = frame_node == node_addr[7:0]; // RQ9
		ser_cfg.baud_ok   = 1'b1;
		ser_cfg.two_stop  = serial[FRAME_LSB +: 2] == 2'b01; // RQ10
		case (serial[FRAME_LSB +: 2])
			2'b10:   ser_cfg.parity = PAR_EVEN;
			2'b11:   ser_cfg.parity = PAR_ODD;
			default: ser_cfg.parity = PAR_NONE;
		endcase
		case (serial[BAUD_LSB +: 6]) // RQ12
			6'h03:   ser_cfg.baud_rate = 17'd1200;
			6'h04:   ser_cfg.baud_rate = 17'd2400;
			6'h05:   ser_cfg.baud_rate = 17'd4800;
			6'h06:   ser_cfg.baud_rate = 17'd9600;
			6'h07:   ser_cfg.baud_rate = 17'd19200;
			6'h08:   ser_cfg.baud_rate = 17'd38400;
			6'h09:   ser_cfg.baud_rate = 17'd57600;
			6'h0a:   ser_cfg.baud_rate = 17'd115200;
			default: begin
				ser_cfg.baud_rate = 17'd9600;
				ser_cfg.baud_ok   = 1'b0;
			end
		endcase
	end

	// ------------------------------------------------------------
	// response delay
	// ------------------------------------------------------------
	// delay is sampled at request time; a later write does not shorten it
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			dly_st  <= DLY_IDLE;
			ms_left <= '0;
			ms_cnt  <= '0;
		end else begin
			case (dly_st)
				DLY_IDLE: if (resp_req) begin
					ms_left <= delay_ms[4:0];
					ms_cnt  <= '0;
					dly_st  <= delay_ms == RST_ZERO ? DLY_GO : DLY_WAIT; // RQ8
				end
				DLY_WAIT: if (ms_cnt == 20'(MS_CYCLES - 1)) begin
					ms_cnt  <= '0;
					ms_left <= ms_left - 5'h01;
					if (ms_left == 5'h01)
						dly_st <= DLY_GO; // RQ8
				end else begin
					ms_cnt <= ms_cnt + 20'h00001;
				end
				DLY_GO:   dly_st <= DLY_IDLE;
				default:  dly_st <= DLY_IDLE;
			endcase
		end
	end

	assign resp_go = dly_st == DLY_GO;

	// ------------------------------------------------------------
	// read side and answer
	// ------------------------------------------------------------
	aomrm_rsp_t next_rsp;
	int         rb_ch;
	int         di_ch;

	always_comb begin
		rb_ch          = ch_of(req.addr, A_RDBK);
		di_ch          = ch_of(req.addr, A_DICNT);
		next_rsp.ack   = req.rd || req.wr;
		next_rsp.err   = req.wr && wr_bad;
		next_rsp.rdata = 16'h0000;
		if (ao_ch >= 0)
			next_rsp.rdata = ao_val[ao_ch];
		else if (safe_ch >= 0)
			next_rsp.rdata = safe_val[safe_ch];
		else if (pwr_ch >= 0)
			next_rsp.rdata = pwron_val[pwr_ch];
		else if (rb_ch >= 0)
			next_rsp.rdata = fmt_eng ? to_eng(type_code, out_code[rb_ch]) : out_code[rb_ch]; // RQ4
		else if (di_ch >= 0)
			next_rsp.rdata = req.wr ? 16'h0000 : di_count[di_ch];
		else begin
			case (req.addr)
				A_PROTO:  next_rsp.rdata = {15'h0000, proto_modbus};
				A_WDMODE: next_rsp.rdata = {15'h0000, wd_mode};
				A_WDEN:   next_rsp.rdata = {15'h0000, wd_en};
				A_FMT:    next_rsp.rdata = {15'h0000, fmt_eng};
				A_WDFLAG: next_rsp.rdata = {15'h0000, wd_timeout};
				A_FIRST:  next_rsp.rdata = {15'h0000, first_rd}; // RQ6
				A_FWLO:   next_rsp.rdata = FW_LO;
				A_FWHI:   next_rsp.rdata = FW_HI;
				A_NAMELO: next_rsp.rdata = NAME_LO;
				A_NAMEHI: next_rsp.rdata = NAME_HI;
				A_NODE:   next_rsp.rdata = node_addr;
				A_SERIAL: next_rsp.rdata = serial;
				A_TYPE:   next_rsp.rdata = type_code;
				A_DELAY:  next_rsp.rdata = delay_ms;
				A_WDTO:   next_rsp.rdata = wdto;
				A_TALLY:  next_rsp.rdata = tally;
				A_SLEW:   next_rsp.rdata = slew_rate;
				default:  next_rsp.err = next_rsp.ack;
			endcase
		end
		// read-only registers refuse writes
		if (req.wr && (rb_ch >= 0 || di_ch >= 0 || req.addr == A_FIRST
			|| (req.addr >= A_FWLO && req.addr <= A_NAMEHI)))
			next_rsp.err = 1'b1;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			rsp <= '0;
		else
			rsp <= next_rsp;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			first_rd <= 1'b1;
		else if (req.rd && req.addr == A_FIRST)
			first_rd <= 1'b0; // RQ6
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	AST_PROTO: assert property (req.wr && req.addr == A_PROTO |=> proto_modbus == $past(req.wdata[0])) // RQ1
		else $error("protocol coil did not follow write");
	AST_MODE_CLEAR: assert property (wd_mode && ao_wr && !expire |=> !wd_timeout) // RQ2
		else $error("output write did not clear timeout in mode 1");
	AST_MODE_KEEP: assert property (!wd_mode && wd_timeout && !(req.wr && req.addr == A_WDFLAG)
		|=> wd_timeout) // RQ2
		else $error("timeout cleared without write-one in mode 0");
	AST_WD_OFF: assert property (!wd_en && !wd_timeout |=> !wd_timeout) // RQ3
		else $error("watchdog expired while disabled");
	AST_FMT_HEX: assert property (!fmt_eng && !wd_timeout ##1 !fmt_eng && !wd_timeout
		|-> out_code[0] == $past(ao_val[0])) // RQ4
		else $error("hex format output not passed through");
	AST_SET_WINS: assert property (expire |=> wd_timeout && tally != RST_ZERO) // RQ5
		else $error("expiry lost or tally not counted");
	AST_FIRST: assert property (req.rd && req.addr == A_FIRST && first_rd
		|=> rsp.rdata == 16'h0001 ##1 !first_rd) // RQ6
		else $error("power-up flag read wrong");
	AST_TALLY_CLR: assert property (req.wr && req.addr == A_TALLY && req.wdata == RST_ZERO && !expire
		|=> tally == RST_ZERO) // RQ7
		else $error("tally not cleared by zero write");
	AST_DELAY_BAD: assert property (req.wr && req.addr == A_DELAY && req.wdata > DELAY_MAX
		|=> rsp.err && $stable(delay_ms)) // RQ8
		else $error("out of range delay accepted");
	AST_DELAY_ZERO: assert property (dly_st == DLY_IDLE && resp_req && delay_ms == RST_ZERO
		|=> resp_go ##1 !resp_go) // RQ8
		else $error("zero delay response not immediate");
	AST_NODE_BAD: assert property (req.wr && req.addr == A_NODE && req.wdata == 16'h0000
		|=> rsp.err && node_addr != 16'h0000) // RQ9
		else $error("node address zero accepted");

	COV_EXPIRE: cover property (expire);
	COV_W1C: cover property (wd_timeout ##1 !wd_timeout);
	COV_DELAYED: cover property (dly_st == DLY_WAIT ##1 resp_go);
	COV_FIRST: cover property (req.rd && req.addr == A_FIRST && first_rd);
endmodule
